/* File: logic/adc_out_pkg.sv */
/*
  Shared constants for the dual-channel converter output interface:
  register addresses, field positions, reset values, output modes and
  timing counts.
  Assumes a 125 MHz control clock and an 8-bit register port.
*/
package adc_out_pkg;

  // Register port geometry
  localparam int DATA_W = 8;
  localparam int ADDR_W = 4;
  localparam int SAMPLE_W = 12;

  // Register addresses
  localparam logic [3:0] CLOCK_CONFIG_ADDR = 4'h2;
  localparam logic [3:0] OUTPUT_CONFIG_ADDR = 4'h3;
  localparam logic [3:0] STATUS_ADDR = 4'h7;

  // Clock configuration fields
  localparam int DCS_EN_BIT = 0;
  localparam logic [7:0] CLOCK_CONFIG_RST = 8'h00;

  // Output configuration fields
  localparam int MODE_LSB = 0;
  localparam int MODE_MSB = 1;
  localparam int CUR_LSB = 4;
  localparam int CUR_MSB = 6;
  localparam logic [7:0] OUTPUT_CONFIG_RST = 8'h00;
  // Current code 0 is the standard 3.5 mA drive
  localparam logic [2:0] LVDS_CUR_DEFAULT = 3'h0;

  // Status fields
  localparam int ST_NAP_BIT = 0;
  localparam int ST_SETTLED_BIT = 1;
  localparam int ST_SINGLE_BIT = 2;
  localparam int ST_DUTY_BIT = 3;
  localparam int ST_MODE_LSB = 4;
  localparam int ST_MODE_MSB = 5;
  localparam int ST_PAR_BIT = 6;

  // Output modes
  typedef enum logic [1:0] {FULL_CMOS, DDR_CMOS, DDR_LVDS} out_mode_t;

  // Control clock and encode timing
  localparam int CLK_PERIOD_PS = 8000;
  localparam int NAP_PERIOD_NS = 2000;
  localparam int NAP_CYCLES = (NAP_PERIOD_NS * 1000) / CLK_PERIOD_PS;
  localparam int CNT_W = 9;
  localparam int LOCK_CYCLES = 100;
  localparam int LOCK_W = 7;
  localparam int PERIOD_TOL = 1;

  // Duty cycle windows in percent
  localparam int DUTY_DCS_MIN = 30;
  localparam int DUTY_DCS_MAX = 70;
  localparam int DUTY_RAW_MIN = 45;
  localparam int DUTY_RAW_MAX = 55;
  localparam int PCT_FULL = 100;
  localparam int PROD_W = 16;

endpackage

/* File: logic/sync_bits.sv */
/*
  Two-stage synchroniser for slow levels, parameterised in width.
  Assumes each bit is a quasi-static level; multi-bit words need a
  stability filter after it.
*/
`timescale 1ns/1ps
module sync_bits #(
  parameter int WIDTH = 1
) (
  // Destination clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Level in and synchronised level out
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] stage1;

  // First stage feeds only the second
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      stage1 <= '0;
      q_o <= '0;
    end else begin
      stage1 <= d_i;
      q_o <= stage1;
    end
  end

endmodule

/* File: logic/ddr_lane.sv */
/*
  One channel's output lane: full-rate lines and double-rate pair lines.
  Assumes capture_i is high in the cycle before the output clock falls,
  and that the link clock runs at twice the sample rate.
*/
`timescale 1ns/1ps
module ddr_lane #(
  parameter int SAMPLE_W = 12
) (
  // Link clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Mode and timing
  input wire logic capture_i,
  input wire logic ddr_i,
  input wire logic lvds_i,
  // Sample from the converter core
  input wire logic [SAMPLE_W-1:0] sample_i,
  // Line outputs
  output logic [SAMPLE_W-1:0] full_line_o,
  output logic [SAMPLE_W/2-1:0] pair_line_o,
  output logic [SAMPLE_W/2-1:0] pair_line_n_o
);

  logic [SAMPLE_W-1:0] hold;
  logic [SAMPLE_W/2-1:0] next_pair;

  // Even bits of a new sample, else odd bits of the held one
  always_comb begin
    next_pair = '0;
    for (int i = 0; i < SAMPLE_W/2; i++) begin
      if (!ddr_i) begin
        next_pair[i] = 1'b0;
      end else if (capture_i) begin
        next_pair[i] = sample_i[2*i];
      end else begin
        next_pair[i] = hold[2*i+1];
      end
    end
  end

  // Line registers
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      hold <= '0;
      full_line_o <= '0;
      pair_line_o <= '0;
      pair_line_n_o <= '0;
    end else begin
      if (capture_i) begin
        hold <= sample_i;
        full_line_o <= ddr_i ? '0 : sample_i;
      end
      pair_line_o <= next_pair;
      pair_line_n_o <= lvds_i ? ~next_pair : '0;
    end
  end

endmodule

/* File: logic/dual_adc_output_interface.sv */
/*
  Digital side of a two-channel converter: encode monitoring, nap on
  clock loss, stabilizer lock tracking, register port and the three
  sample output modes.
  Assumes bit_clk_i is the regenerated internal clock at twice the
  encode rate, and that the core's samples arrive on bit_clk_i.
*/
// What this block does
// - Both channels captured on one shared strobe in the same cycle.
// - Grounded negative encode input selects single-ended encode, else differential.
// - Encode stopped or slower than about 500 kHz puts the block in nap.
// - Stabilizer on accepts 30 to 70 percent duty, regenerates 50 percent.
// - With the stabilizer on, settling after an encode frequency change needs one hundred encode cycles.
// - Stabilizer enable from clock config register, or chip-select pin in parallel.
// - Output mode from output config register, or serial-clock pin in parallel.
// - Parallel configuration offers only full rate CMOS and double rate LVDS.
// - Full rate CMOS drives twelve lines, own overflow per channel, clock pair.
// - Double rate CMOS puts two bits per line, six lines per channel.
// - Double rate modes share one overflow output between both channels.
// - Double rate LVDS uses differential pairs for data, overflow and clock.
// - Differential drivers default to standard levels with 3.5 mA current.
// - Double rate: even bits while clock low, odd bits while clock high.
// - Shared overflow: channel 2 while clock low, channel 1 while high.
// - Full rate data changes with the falling edge of the output clock.
`timescale 1ns/1ps
module dual_adc_output_interface #(
  parameter int SAMPLE_W = adc_out_pkg::SAMPLE_W
) (
  // Control clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Register port
  input wire logic [adc_out_pkg::ADDR_W-1:0] addr_i,
  input wire logic [adc_out_pkg::DATA_W-1:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [adc_out_pkg::DATA_W-1:0] rd_data_o,
  // Configuration pins
  input wire logic config_style_pin_i,
  input wire logic cs_pin_i,
  input wire logic sck_pin_i,
  // Encode input levels
  input wire logic encode_in_pos_i,
  input wire logic encode_in_neg_i,
  // Control-side status
  output logic nap_o,
  output logic settled_o,
  output logic single_ended_o,
  output logic dcs_en_o,
  output logic [2:0] lvds_current_o,
  // Link clock and core samples
  input wire logic bit_clk_i,
  input wire logic [SAMPLE_W-1:0] ch1_sample_i,
  input wire logic [SAMPLE_W-1:0] ch2_sample_i,
  input wire logic ch1_over_i,
  input wire logic ch2_over_i,
  // Full rate lines
  output logic [SAMPLE_W-1:0] ch1_bit_line_o,
  output logic [SAMPLE_W-1:0] ch2_bit_line_o,
  output logic ch1_overrange_out_o,
  output logic ch2_overrange_out_o,
  // Double rate lines
  output logic [SAMPLE_W/2-1:0] ch1_bit_pair_line_o,
  output logic [SAMPLE_W/2-1:0] ch2_bit_pair_line_o,
  output logic [SAMPLE_W/2-1:0] ch1_bit_pair_line_n_o,
  output logic [SAMPLE_W/2-1:0] ch2_bit_pair_line_n_o,
  output logic shared_overrange_out_o,
  output logic shared_overrange_out_n_o,
  // Output clock and driver mode
  output logic sample_clock_out_pos_o,
  output logic sample_clock_out_neg_o,
  output logic lvds_mode_o
);

  localparam logic [adc_out_pkg::CNT_W-1:0] NAP_LIMIT =
    adc_out_pkg::CNT_W'(adc_out_pkg::NAP_CYCLES);
  localparam logic [adc_out_pkg::LOCK_W-1:0] LOCK_LIMIT =
    adc_out_pkg::LOCK_W'(adc_out_pkg::LOCK_CYCLES);
  localparam logic [adc_out_pkg::CNT_W-1:0] TOL =
    adc_out_pkg::CNT_W'(adc_out_pkg::PERIOD_TOL);

  // Control-domain state
  logic [7:0] clock_config;
  logic [7:0] output_config;
  logic par_s;
  logic cs_s;
  logic sck_s;
  logic enc_s;
  logic neg_s;
  logic enc_d;
  logic enc_rise;
  logic [adc_out_pkg::CNT_W-1:0] per_cnt;
  logic [adc_out_pkg::CNT_W-1:0] hi_cnt;
  logic [adc_out_pkg::CNT_W-1:0] last_per;
  logic have_per;
  logic freq_change;
  logic [adc_out_pkg::LOCK_W-1:0] lock_cnt;
  logic duty_ok;
  logic dcs_en;
  adc_out_pkg::out_mode_t mode_sys;
  logic [adc_out_pkg::PROD_W-1:0] hi_pct;
  logic [adc_out_pkg::PROD_W-1:0] per_lo;
  logic [adc_out_pkg::PROD_W-1:0] per_hi;

  // Link-domain state
  logic link_rst_n;
  logic nap_link;
  logic [1:0] mode_s;
  logic [1:0] mode_prev;
  adc_out_pkg::out_mode_t mode_link;
  logic phase;
  logic capture;
  logic ddr;
  logic lvds;
  logic ov1_hold;
  logic next_shared;

  // Pin synchronisers on the control clock
  sync_bits #(.WIDTH(5)) u_pin_sync (
    .clk_i(clock_i),
    .rst_n_i(rst_n_i),
    .d_i({config_style_pin_i, cs_pin_i, sck_pin_i, encode_in_pos_i, encode_in_neg_i}),
    .q_o({par_s, cs_s, sck_s, enc_s, neg_s})
  );

  // Effective stabilizer enable
  always_comb begin
    dcs_en = par_s ? cs_s : clock_config[adc_out_pkg::DCS_EN_BIT];
  end

  // Effective output mode; parallel offers no double rate CMOS
  always_comb begin
    mode_sys = adc_out_pkg::FULL_CMOS;
    if (par_s) begin
      mode_sys = sck_s ? adc_out_pkg::DDR_LVDS : adc_out_pkg::FULL_CMOS;
    end else begin
      case (output_config[adc_out_pkg::MODE_MSB:adc_out_pkg::MODE_LSB])
        2'h1: mode_sys = adc_out_pkg::DDR_CMOS;
        2'h2: mode_sys = adc_out_pkg::DDR_LVDS;
        default: mode_sys = adc_out_pkg::FULL_CMOS;
      endcase
    end
  end

  // Register writes
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      clock_config <= adc_out_pkg::CLOCK_CONFIG_RST;
      output_config <= adc_out_pkg::OUTPUT_CONFIG_RST;
    end else if (wr_i) begin
      if (addr_i == adc_out_pkg::CLOCK_CONFIG_ADDR) begin
        clock_config <= wr_data_i;
      end
      if (addr_i == adc_out_pkg::OUTPUT_CONFIG_ADDR) begin
        output_config <= wr_data_i;
      end
    end
  end

  // Register reads, data valid the cycle after the strobe
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      rd_data_o <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        adc_out_pkg::CLOCK_CONFIG_ADDR: rd_data_o <= clock_config;
        adc_out_pkg::OUTPUT_CONFIG_ADDR: rd_data_o <= output_config;
        adc_out_pkg::STATUS_ADDR: begin
          rd_data_o <= 8'h00;
          rd_data_o[adc_out_pkg::ST_NAP_BIT] <= nap_o;
          rd_data_o[adc_out_pkg::ST_SETTLED_BIT] <= settled_o;
          rd_data_o[adc_out_pkg::ST_SINGLE_BIT] <= single_ended_o;
          rd_data_o[adc_out_pkg::ST_DUTY_BIT] <= duty_ok;
          rd_data_o[adc_out_pkg::ST_MODE_MSB:adc_out_pkg::ST_MODE_LSB] <= mode_sys;
          rd_data_o[adc_out_pkg::ST_PAR_BIT] <= par_s;
        end
        default: rd_data_o <= 8'h00;
      endcase
    end else begin
      rd_data_o <= 8'h00;
    end
  end

  // Encode edge detection on the synchronised level
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      enc_d <= 1'b0;
    end else begin
      enc_d <= enc_s;
    end
  end

  assign enc_rise = enc_s & ~enc_d;

  // Encode style from the negative input level
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      single_ended_o <= 1'b0;
    end else begin
      single_ended_o <= ~neg_s;
    end
  end

  // Period and high-time counters, saturating at the nap limit
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      per_cnt <= '0;
      hi_cnt <= '0;
    end else if (enc_rise) begin
      per_cnt <= '0;
      hi_cnt <= '0;
    end else begin
      if (per_cnt != NAP_LIMIT) begin
        per_cnt <= per_cnt + 1'b1;
      end
      if (enc_s && hi_cnt != NAP_LIMIT) begin
        hi_cnt <= hi_cnt + 1'b1;
      end
    end
  end

  // Nap when no encode rise in the slow-clock period; a rise wakes at once
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      nap_o <= 1'b1;
    end else if (enc_rise) begin
      nap_o <= 1'b0;
    end else if (per_cnt == NAP_LIMIT) begin
      nap_o <= 1'b1;
    end
  end

  // Frequency change: new period differs from the last by more than tolerance
  always_comb begin
    freq_change = 1'b0;
    if (!have_per) begin
      freq_change = 1'b1;
    end else if (per_cnt > last_per + TOL || last_per > per_cnt + TOL) begin
      freq_change = 1'b1;
    end
  end

  // Remember the last full period
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      last_per <= '0;
      have_per <= 1'b0;
    end else if (nap_o && !enc_rise) begin
      have_per <= 1'b0;
    end else if (enc_rise) begin
      last_per <= per_cnt;
      have_per <= 1'b1;
    end
  end

  // Lock count of encode cycles since the last frequency change
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      lock_cnt <= '0;
    end else if (nap_o) begin
      lock_cnt <= '0;
    end else if (enc_rise) begin
      if (freq_change) begin
        lock_cnt <= '0;
      end else if (lock_cnt != LOCK_LIMIT) begin
        lock_cnt <= lock_cnt + 1'b1;
      end
    end
  end

  // Settled when locked, or at once with the stabilizer off
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      settled_o <= 1'b0;
    end else begin
      settled_o <= ~nap_o & (~dcs_en | (lock_cnt == LOCK_LIMIT));
    end
  end

  // Duty products in percent of the period
  assign hi_pct = adc_out_pkg::PROD_W'(hi_cnt) * adc_out_pkg::PROD_W'(adc_out_pkg::PCT_FULL);
  assign per_lo = adc_out_pkg::PROD_W'(per_cnt) * (dcs_en
    ? adc_out_pkg::PROD_W'(adc_out_pkg::DUTY_DCS_MIN)
    : adc_out_pkg::PROD_W'(adc_out_pkg::DUTY_RAW_MIN));
  assign per_hi = adc_out_pkg::PROD_W'(per_cnt) * (dcs_en
    ? adc_out_pkg::PROD_W'(adc_out_pkg::DUTY_DCS_MAX)
    : adc_out_pkg::PROD_W'(adc_out_pkg::DUTY_RAW_MAX));

  // Duty window check once per encode period
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      duty_ok <= 1'b0;
    end else if (nap_o) begin
      duty_ok <= 1'b0;
    end else if (enc_rise) begin
      duty_ok <= (hi_pct >= per_lo) && (hi_pct <= per_hi);
    end
  end

  // Driver settings to the pads
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      dcs_en_o <= 1'b0;
      lvds_current_o <= adc_out_pkg::LVDS_CUR_DEFAULT;
    end else begin
      dcs_en_o <= dcs_en;
      lvds_current_o <= output_config[adc_out_pkg::CUR_MSB:adc_out_pkg::CUR_LSB];
    end
  end

  // Reset, nap and mode crossing into the link domain
  sync_bits #(.WIDTH(1)) u_rst_sync (
    .clk_i(bit_clk_i),
    .rst_n_i(1'b1),
    .d_i(rst_n_i),
    .q_o(link_rst_n)
  );

  sync_bits #(.WIDTH(3)) u_cfg_sync (
    .clk_i(bit_clk_i),
    .rst_n_i(link_rst_n),
    .d_i({nap_o, mode_sys}),
    .q_o({nap_link, mode_s})
  );

  // Mode accepted only once stable for two link cycles
  always_ff @(posedge bit_clk_i) begin
    if (!link_rst_n) begin
      mode_prev <= 2'h0;
      mode_link <= adc_out_pkg::FULL_CMOS;
    end else begin
      mode_prev <= mode_s;
      if (mode_s == mode_prev) begin
        case (mode_s)
          2'h1: mode_link <= adc_out_pkg::DDR_CMOS;
          2'h2: mode_link <= adc_out_pkg::DDR_LVDS;
          default: mode_link <= adc_out_pkg::FULL_CMOS;
        endcase
      end
    end
  end

  assign ddr = (mode_link != adc_out_pkg::FULL_CMOS);
  assign lvds = (mode_link == adc_out_pkg::DDR_LVDS);

  // Half-sample phase: 0 is clock low, 1 is clock high
  always_ff @(posedge bit_clk_i) begin
    if (!link_rst_n) begin
      phase <= 1'b0;
    end else if (nap_link) begin
      phase <= 1'b0;
    end else begin
      phase <= ~phase;
    end
  end

  // One strobe captures both channels together
  assign capture = phase & ~nap_link;

  // Output clock falls as new data appears; parks high on odd bits in nap
  always_ff @(posedge bit_clk_i) begin
    if (!link_rst_n) begin
      sample_clock_out_pos_o <= 1'b0;
      sample_clock_out_neg_o <= 1'b1;
      lvds_mode_o <= 1'b0;
    end else begin
      sample_clock_out_pos_o <= ~phase;
      sample_clock_out_neg_o <= phase;
      lvds_mode_o <= lvds;
    end
  end

  // Channel lanes share the capture strobe
  ddr_lane #(.SAMPLE_W(SAMPLE_W)) u_lane1 (
    .clk_i(bit_clk_i),
    .rst_n_i(link_rst_n),
    .capture_i(capture),
    .ddr_i(ddr),
    .lvds_i(lvds),
    .sample_i(ch1_sample_i),
    .full_line_o(ch1_bit_line_o),
    .pair_line_o(ch1_bit_pair_line_o),
    .pair_line_n_o(ch1_bit_pair_line_n_o)
  );

  ddr_lane #(.SAMPLE_W(SAMPLE_W)) u_lane2 (
    .clk_i(bit_clk_i),
    .rst_n_i(link_rst_n),
    .capture_i(capture),
    .ddr_i(ddr),
    .lvds_i(lvds),
    .sample_i(ch2_sample_i),
    .full_line_o(ch2_bit_line_o),
    .pair_line_o(ch2_bit_pair_line_o),
    .pair_line_n_o(ch2_bit_pair_line_n_o)
  );

  // Shared overflow: channel 2 in the low half, channel 1 in the high half
  always_comb begin
    next_shared = 1'b0;
    if (ddr) begin
      next_shared = capture ? ch2_over_i : ov1_hold;
    end
  end

  // Overflow registers
  always_ff @(posedge bit_clk_i) begin
    if (!link_rst_n) begin
      ov1_hold <= 1'b0;
      ch1_overrange_out_o <= 1'b0;
      ch2_overrange_out_o <= 1'b0;
      shared_overrange_out_o <= 1'b0;
      shared_overrange_out_n_o <= 1'b0;
    end else begin
      if (capture) begin
        ov1_hold <= ch1_over_i;
        ch1_overrange_out_o <= ddr ? 1'b0 : ch1_over_i;
        ch2_overrange_out_o <= ddr ? 1'b0 : ch2_over_i;
      end
      shared_overrange_out_o <= next_shared;
      shared_overrange_out_n_o <= lvds ? ~next_shared : 1'b0;
    end
  end

endmodule

/* File: verif/adc_out_assertions.sv */
/* Checker for the converter output block: encode, nap, settle, pins, lines.
   Assumes it is bound into the block and sees its ports only. */
`timescale 1ns/1ps
module adc_out_assertions #(
  parameter int SAMPLE_W = 12
) (
  // Clocks and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic bit_clk_i,
  // Register read side
  input wire logic rd_i,
  input wire logic [7:0] rd_data_o,
  // Pins and status
  input wire logic encode_in_pos_i,
  input wire logic encode_in_neg_i,
  input wire logic config_style_pin_i,
  input wire logic cs_pin_i,
  input wire logic nap_o,
  input wire logic settled_o,
  input wire logic single_ended_o,
  input wire logic dcs_en_o,
  // Link lines
  input wire logic [SAMPLE_W-1:0] ch1_bit_line_o,
  input wire logic [SAMPLE_W/2-1:0] ch1_bit_pair_line_o,
  input wire logic [SAMPLE_W/2-1:0] ch1_bit_pair_line_n_o,
  input wire logic sample_clock_out_pos_o,
  input wire logic sample_clock_out_neg_o,
  input wire logic lvds_mode_o
);
  logic enc_q;
  logic enc_rise;
  logic [9:0] idle_cnt;
  logic [7:0] rise_cnt;
  assign enc_rise = encode_in_pos_i && !enc_q;
  // Cycles since the last raw encode rise
  always_ff @(posedge clock_i) begin
    enc_q <= encode_in_pos_i;
    if (!rst_n_i || enc_rise) idle_cnt <= 10'h000;
    else if (idle_cnt != 10'h3FF) idle_cnt <= idle_cnt + 10'h001;
  end
  // Encode rises seen since nap ended
  always_ff @(posedge clock_i) begin
    if (!rst_n_i || nap_o) rise_cnt <= 8'h00;
    else if (enc_rise && rise_cnt != 8'hFF) rise_cnt <= rise_cnt + 8'h01;
  end
  sequence s_napping;
    nap_o ##1 nap_o;
  endsequence
  a_nap_enter: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    idle_cnt == 10'h12C |-> nap_o) else $error("no nap on stopped encode");
  a_nap_exit: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    nap_o && enc_rise |-> ##[1:8] !nap_o) else $error("nap kept");
  a_nap_unsettled: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    s_napping |-> !settled_o) else $error("settled in nap");
  a_settle_wait: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    $rose(settled_o) && dcs_en_o |-> rise_cnt >= 8'h62) else $error("early lock");
  a_single_end: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (!encode_in_neg_i)[*6] |=> single_ended_o) else $error("no single");
  a_diff_enc: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    encode_in_neg_i[*6] |=> !single_ended_o) else $error("no differential");
  a_read_idle: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !rd_i |=> rd_data_o == 8'h00) else $error("read data outside slot");
  a_dcs_pin: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (config_style_pin_i && cs_pin_i)[*6] |=> dcs_en_o) else $error("pin dcs");
  a_clk_pair: assert property (@(posedge bit_clk_i) disable iff (!rst_n_i)
    sample_clock_out_neg_o == !sample_clock_out_pos_o) else $error("clock pair");
  a_full_fall: assert property (@(posedge bit_clk_i) disable iff (!rst_n_i)
    $changed(ch1_bit_line_o) |-> $fell(sample_clock_out_pos_o)) else $error("full");
  a_pair_half: assert property (@(posedge bit_clk_i) disable iff (!rst_n_i)
    $changed(ch1_bit_pair_line_o) |-> $changed(sample_clock_out_pos_o)) else $error("ddr");
  a_lvds_leg: assert property (@(posedge bit_clk_i) disable iff (!rst_n_i)
    lvds_mode_o && $past(lvds_mode_o, 2) |-> ch1_bit_pair_line_n_o == ~ch1_bit_pair_line_o)
    else $error("lvds leg");
endmodule
bind dual_adc_output_interface adc_out_assertions #(.SAMPLE_W(SAMPLE_W)) chk_u (.*);

/* File: verif/adc_rx_model.sv */
/* Receiver model: rebuilds both channels' samples from the output lines.
   Assumes the bench tells it which mode is configured. */
`timescale 1ns/1ps
module adc_rx_model (
  // Link clock and configured mode
  input wire logic clk_i,
  input wire logic [1:0] mode_i,
  // Lines from the converter
  input wire logic clk_pos_i,
  input wire logic [11:0] full1_i,
  input wire logic [11:0] full2_i,
  input wire logic of1_i,
  input wire logic of2_i,
  input wire logic [5:0] pair1_i,
  input wire logic [5:0] pair2_i,
  input wire logic [5:0] pair1_n_i,
  input wire logic [5:0] pair2_n_i,
  input wire logic shared_i,
  input wire logic shared_n_i,
  // Rebuilt sample
  output logic res_v_o,
  output logic [25:0] res_o
);
  logic prev;
  logic ov2;
  logic sh;
  logic [5:0] ev1, ev2, d1, d2;
  // Differential mode reads the inverted negative leg
  assign d1 = (mode_i == 2'h2) ? ~pair1_n_i : pair1_i;
  assign d2 = (mode_i == 2'h2) ? ~pair2_n_i : pair2_i;
  assign sh = (mode_i == 2'h2) ? ~shared_n_i : shared_i;
  function automatic logic [11:0] weave(input logic [5:0] e, input logic [5:0] o);
    for (int i = 0; i < 6; i++) begin
      weave[2*i] = e[i];
      weave[2*i+1] = o[i];
    end
  endfunction
  // Low half holds even bits and channel 2 overflow
  always_ff @(posedge clk_i) begin
    prev <= clk_pos_i;
    if (!clk_pos_i) begin
      ev1 <= d1;
      ev2 <= d2;
      ov2 <= sh;
    end
  end
  // Rising output clock completes a sample
  always_ff @(posedge clk_i) begin
    res_v_o <= clk_pos_i && !prev;
    if (clk_pos_i && !prev) begin
      if (mode_i == 2'h0) res_o <= {of2_i, of1_i, full2_i, full1_i};
      else res_o <= {ov2, sh, weave(ev2, d2), weave(ev1, d1)};
    end
  end
endmodule

/* File: verif/dual_adc_output_interface_bench.sv */
/* Self-checking bench: registers, encode, nap, pins and all output modes.
   Assumes the receiver model and the bound checker. */
`timescale 1ns/1ps
module dual_adc_output_interface_bench;
  logic clock_i = 1'b0, bit_clk_i = 1'b0, rst_n_i = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wr_data_i = 8'h00, rd_data_o;
  logic wr_i = 1'b0, rd_i = 1'b0, rd_seen = 1'b0;
  logic config_style_pin_i = 1'b0, cs_pin_i = 1'b0, sck_pin_i = 1'b0;
  logic encode_in_pos_i = 1'b0, encode_in_neg_i = 1'b1, enc_run = 1'b0;
  logic nap_o, settled_o, single_ended_o, dcs_en_o, lvds_mode_o, res_v;
  logic [2:0] lvds_current_o, cur;
  logic [11:0] ch1_sample_i = 12'h000, ch2_sample_i = 12'h000;
  logic ch1_over_i = 1'b0, ch2_over_i = 1'b0;
  logic [11:0] ch1_bit_line_o, ch2_bit_line_o;
  logic [5:0] ch1_bit_pair_line_o, ch2_bit_pair_line_o;
  logic [5:0] ch1_bit_pair_line_n_o, ch2_bit_pair_line_n_o;
  logic ch1_overrange_out_o, ch2_overrange_out_o;
  logic shared_overrange_out_o, shared_overrange_out_n_o;
  logic sample_clock_out_pos_o, sample_clock_out_neg_o;
  logic [1:0] rx_mode = 2'h0;
  logic [25:0] res;
  logic [7:0] rdq[$], rmq[$];
  logic [25:0] smq[$];
  int error_cnt = 0, check_count = 0;
  dual_adc_output_interface dut_u (.*);
  adc_rx_model rx_u (.clk_i(bit_clk_i), .mode_i(rx_mode), .clk_pos_i(sample_clock_out_pos_o),
    .full1_i(ch1_bit_line_o), .full2_i(ch2_bit_line_o), .of1_i(ch1_overrange_out_o),
    .of2_i(ch2_overrange_out_o), .pair1_i(ch1_bit_pair_line_o), .pair2_i(ch2_bit_pair_line_o),
    .pair1_n_i(ch1_bit_pair_line_n_o), .pair2_n_i(ch2_bit_pair_line_n_o),
    .shared_i(shared_overrange_out_o), .shared_n_i(shared_overrange_out_n_o),
    .res_v_o(res_v), .res_o(res));
  // Control clock, link clock and encode square wave
  always #4 clock_i = ~clock_i;
  initial begin
    #3;
    forever #7.5 bit_clk_i = ~bit_clk_i;
  end
  initial begin
    #1;
    forever #80 if (enc_run) encode_in_pos_i = ~encode_in_pos_i;
  end
  task automatic close_out();
    if (error_cnt == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic fail(input string s);
    error_cnt++;
    $display("CHECK FAILED %0t %s", $time, s);
  endtask
  task automatic cmp_flag(input logic [2:0] g, input logic [2:0] e);
    check_count++;
    if (g !== e) fail("status output");
  endtask
  task automatic cmp_rd(input logic [7:0] g, input logic [7:0] e, input logic [7:0] m);
    check_count++;
    if ((g & m) !== (e & m)) fail("read data");
  endtask
  task automatic cmp_smp(input logic [25:0] g, input logic [25:0] e);
    check_count++;
    if (g !== e) fail("received sample");
  endtask
  // Register bus cycles
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wr_data_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'b1;
    rdq.push_back(e);
    rmq.push_back(m);
    @(posedge clock_i);
    rd_i <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  always @(posedge clock_i) begin
    if (rd_seen) cmp_rd(rd_data_o, rdq.pop_front(), rmq.pop_front());
    rd_seen <= rd_i;
  end
  // Each rebuilt sample settles the oldest note
  always @(posedge bit_clk_i) begin
    if (res_v === 1'b1 && smq.size() > 0) cmp_smp(res, smq.pop_front());
  end
  // Hold random samples and wait for the receiver to report them
  task automatic send(input int n);
    logic [25:0] v;
    int k;
    repeat (n) begin
      v = $urandom;
      @(posedge bit_clk_i);
      {ch2_over_i, ch1_over_i, ch2_sample_i, ch1_sample_i} <= v;
      repeat (8) @(posedge bit_clk_i);
      smq.push_back(v);
      k = 0;
      while (smq.size() > 0 && k < 50) begin
        @(posedge bit_clk_i);
        k++;
      end
      if (k >= 50) begin
        fail("no sample");
        close_out();
      end
    end
  endtask
  task automatic wait_settled(output int k);
    k = 0;
    while (settled_o !== 1'b1 && k < 4000) begin
      @(posedge clock_i);
      k++;
    end
    if (k >= 4000) begin
      fail("never settled");
      close_out();
    end
  endtask
  initial begin
    int k;
    void'($urandom(32'hE0D1));
    repeat (12) @(posedge clock_i);
    rst_n_i <= 1'b1;
    enc_run = 1'b1;
    wr(4'h2, 8'h01);
    cmp_flag(lvds_current_o, 3'h0);
    rd(4'h2, 8'h01, 8'h01);
    rd(4'h5, 8'h00, 8'hFF);
    wait_settled(k);
    cmp_flag(k >= 1900, 1'b1);
    cmp_flag(dcs_en_o, 1'b1);
    wr(4'h7, 8'hFF);
    for (int m = 0; m < 3; m++) begin
      cur = $urandom;
      wr(4'h3, {1'b0, cur, 2'b00, m[1:0]});
      rx_mode = m[1:0];
      repeat (40) @(posedge clock_i);
      rd(4'h3, {1'b0, cur, 2'b00, m[1:0]}, 8'hFF);
      rd(4'h7, {2'b00, m[1:0], 4'hA}, 8'h7F);
      cmp_flag(lvds_mode_o, m == 2);
      cmp_flag(lvds_current_o, cur);
      send(4);
    end
    enc_run = 1'b0;
    repeat (300) @(posedge clock_i);
    cmp_flag(nap_o, 1'b1);
    cmp_flag(settled_o, 1'b0);
    enc_run = 1'b1;
    wait_settled(k);
    cmp_flag(k >= 1900, 1'b1);
    encode_in_neg_i <= 1'b0;
    repeat (20) @(posedge clock_i);
    cmp_flag(single_ended_o, 1'b1);
    encode_in_neg_i <= 1'b1;
    wr(4'h3, 8'h01);
    config_style_pin_i <= 1'b1;
    sck_pin_i <= 1'b1;
    repeat (40) @(posedge clock_i);
    cmp_flag(dcs_en_o, 1'b0);
    cmp_flag(lvds_mode_o, 1'b1);
    rx_mode = 2'h2;
    send(2);
    sck_pin_i <= 1'b0;
    cs_pin_i <= 1'b1;
    repeat (40) @(posedge clock_i);
    rd(4'h7, 8'h40, 8'h70);
    cmp_flag(dcs_en_o, 1'b1);
    rx_mode = 2'h0;
    send(2);
    repeat (4) @(posedge clock_i);
    close_out();
  end
endmodule
